// >>> inc/rcs_pkg.sv
/*
 Shared constants and types of the reset and watchdog supervisor.
 Assumes a 100 MHz system clock; one machine cycle is one clock.
*/
`default_nettype none
package rcs_pkg;
    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [11:0] MISC_OFFSET = 12'h00c;
    localparam logic [11:0] STATUS_OFFSET = 12'h010;
    localparam int POR_BIT = 7;
    localparam int IRQ_RISING_SELECT_BIT = 6;
    localparam int IRQ_FALLING_SELECT_BIT = 5;
    localparam int EXTERNAL_IRQ_ENABLE_BIT = 4;
    localparam int SFA_BIT = 3;
    localparam int SFB_BIT = 2;
    localparam int SM_BIT = 1;
    localparam int SUPERVISOR_ENABLE_BIT_BIT = 0;
    localparam logic [7:0] MISC_RESET = 8'h90;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Values loaded elsewhere on reset
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_VECTOR = 16'h1ffe;
    localparam logic [15:0] TIMER_PRESET = 16'hfffc;
    localparam logic [7:0] SP_PRESET = 8'hff;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MACHINE_CYCLE_NS = 10;
    localparam int EXT_LOW_TENTHS = 15;
    localparam int EXT_LOW_CYC = (EXT_LOW_TENTHS * MACHINE_CYCLE_NS
        + 10 * CLK_PERIOD_NS - 1) / (10 * CLK_PERIOD_NS);
    localparam logic [11:0] SETTLE_SHORT_CYC = 12'h010;
    localparam logic [11:0] SETTLE_LONG_CYC = 12'hfe0;
    localparam logic [11:0] STOP_RESTART_CYC = 12'hfe0;
    localparam int RELEASE_HOLD_NS = 100;
    localparam int RELEASE_HOLD_CYC = (RELEASE_HOLD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [2:0] WD_FINAL = 3'h7;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_OSC_WAIT, S_SETTLE, S_EXT_HOLD, S_RUN, S_COP_PULL, S_STOP_OFF, S_STOP_START
    } rcs_state_t;
    typedef struct packed {
        logic vector_fetch;
        logic i_set;
        logic i_clear;
        logic timer_init;
        logic ddr_clear;
        logic sp_init;
        logic latch_clear;
        logic sci_init;
        logic clk_clear;
        logic adc_off;
        logic nvm_reset;
    } rcs_fx_t;
endpackage
`default_nettype wire

// >>> rtl/rcs_top.sv
/*
 Reset and watchdog supervisor: merges power-on, pin and watchdog
 resets, drives the open-drain reset pin, holds the control register.
 Assumes aresetn is the power-on event and that all inputs are
 synchronous to aclk except the reset pin, which is synchronised here.
*/
// The AXI4-Lite slave port is this design's own decision.
// Summary of operation
// R01: Every reset ends by fetching the reset vector with interrupt mask set.
// R02: After power-up settle, stay in reset while the pin is low.
// R03: Settle lasts 16 or 4064 cycles by option; pin driven low meanwhile.
// R04: Power-on flag set only by power-on; software may only clear it.
// R05: Pin low two cycles resets; run resumes the cycle after it rises.
// R06: Power-on and watchdog resets pull the reset pin low, open drain.
// R07: Watchdog chain is divide by 4, by 256, then a clearable divide by 8.
// R08: Chain advances on the timer bit 7 carry.
// R09: Watchdog enabled by option or software; writing zero never disables.
// R10: Writing one to the enable bit clears the watchdog chain.
// R11: Watchdog resets the chip when its counter reaches seven.
// R12: Watchdog releases the pin after it is sensed low for the hold time.
// R13: Stop while the watchdog runs causes a watchdog reset instead.
// R14: Stop-caused watchdog reset keeps the oscillator and skips settling.
// R15: Option chooses whether the watchdog counts or is held during wait.
// R16: After a watchdog reset the enable bit follows the option.
// R17: Pin and power-on reset init timer, direction regs and stack pointer.
// R18: Pin and power-on reset set irq enable and clear the latches.
// R19: Pin and power-on reset reset the serial port.
// R20: Power-on and stop stop the clocks; stop restarts after 4064 cycles.
// R21: Resets and stop disable converter, slow mode, enable bit, memory bits; resets load the enable bit from the option instead.
// R22: Wait and stop clear the mask; all four events clear the watchdog.
// R23: The reset pin is synchronised before it is timed or acted on.
`default_nettype none
module rcs_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rst_pin_in,
    output var logic rst_pin_out,
    output var logic rst_pin_oe_n,
    input wire logic opt_long_settle,
    input wire logic opt_supervisor_enable_bit_at_reset,
    input wire logic opt_wait_supervisor_enable_bit_run,
    input wire logic osc_stable,
    input wire logic timer_bit7_carry,
    input wire logic stop_req,
    input wire logic stop_wake,
    input wire logic wait_active,
    input wire logic cpu_i_mask,
    output var logic cpu_reset,
    output var logic osc_enable,
    output var logic [7:0] misc_bits,
    output var rcs_pkg::rcs_fx_t reset_fx
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rcs_pkg::rcs_state_t state_r, state_nxt;
    rcs_pkg::rcs_fx_t fx_nxt;
    logic [11:0] cnt_r, cnt_nxt, settle_last;
    logic [1:0] low_cnt_r;
    logic pin_meta_r, pin_sync_r;
    logic [1:0] wd_div4_r;
    logic [7:0] wd_div256_r;
    logic [2:0] wd_div8_r;
    logic wd_clear, wd_tick, wd_timeout, wait_prev_r;
    logic aw_held_r, w_held_r;
    logic [11:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane_r, wr_go, wr_misc, supervisor_enable_bit_write_one;
    logic rst_lvl_nxt, in_reset, stop_enter, wait_rise;

    // ------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------
    // Two stages; only the second is used
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= rst_pin_in;
            pin_sync_r <= pin_meta_r; // [R23]
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Settle length chosen by the static option
    assign settle_last = opt_long_settle ? rcs_pkg::SETTLE_LONG_CYC - 12'h001
        : rcs_pkg::SETTLE_SHORT_CYC - 12'h001; // [R03]
    assign wd_timeout = misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT] && wd_div8_r == rcs_pkg::WD_FINAL;

    // Next state and shared cycle counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = 12'(cnt_r + 12'h001);
        unique case (state_r)
            rcs_pkg::S_OSC_WAIT: begin
                cnt_nxt = 12'h000;
                if (osc_stable) begin
                    state_nxt = rcs_pkg::S_SETTLE;
                end
            end
            rcs_pkg::S_SETTLE: begin
                if (cnt_r == settle_last) begin // [R03]
                    cnt_nxt = 12'h000;
                    state_nxt = rcs_pkg::S_EXT_HOLD; // [R02]
                end
            end
            rcs_pkg::S_EXT_HOLD: begin
                cnt_nxt = 12'h000;
                if (pin_sync_r) begin
                    state_nxt = rcs_pkg::S_RUN; // [R05] [R02]
                end
            end
            rcs_pkg::S_RUN: begin
                cnt_nxt = 12'h000;
                if (!pin_sync_r && low_cnt_r == 2'(rcs_pkg::EXT_LOW_CYC - 1)) begin
                    state_nxt = rcs_pkg::S_EXT_HOLD; // [R05]
                end else if (wd_timeout) begin
                    state_nxt = rcs_pkg::S_COP_PULL; // [R11]
                end else if (stop_req && misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT]) begin
                    state_nxt = rcs_pkg::S_COP_PULL; // [R13] [R14]
                end else if (stop_req) begin
                    state_nxt = rcs_pkg::S_STOP_OFF;
                end
            end
            rcs_pkg::S_COP_PULL: begin
                if (pin_sync_r) begin
                    cnt_nxt = 12'h000; // [R12]
                end else if (cnt_r == 12'(rcs_pkg::RELEASE_HOLD_CYC - 1)) begin
                    cnt_nxt = 12'h000;
                    state_nxt = rcs_pkg::S_EXT_HOLD; // [R12]
                end
            end
            rcs_pkg::S_STOP_OFF: begin
                cnt_nxt = 12'h000;
                if (stop_wake) begin
                    state_nxt = rcs_pkg::S_STOP_START;
                end
            end
            rcs_pkg::S_STOP_START: begin
                if (cnt_r == rcs_pkg::STOP_RESTART_CYC - 12'h001) begin // [R20]
                    cnt_nxt = 12'h000;
                    state_nxt = rcs_pkg::S_RUN;
                end
            end
            default: begin
                cnt_nxt = 12'h000;
                state_nxt = rcs_pkg::S_OSC_WAIT;
            end
        endcase
    end

    // State and counter registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= rcs_pkg::S_OSC_WAIT;
            cnt_r <= 12'h000;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Consecutive low cycles of the pin while running
    always_ff @(posedge aclk) begin
        if (!aresetn || state_r != rcs_pkg::S_RUN || pin_sync_r) begin
            low_cnt_r <= 2'h0;
        end else begin
            low_cnt_r <= 2'(low_cnt_r + 2'h1); // [R05]
        end
    end

    // ------------------------------------------------------------
    // Pin and effect outputs
    // ------------------------------------------------------------
    assign rst_lvl_nxt = state_nxt == rcs_pkg::S_OSC_WAIT || state_nxt == rcs_pkg::S_SETTLE
        || state_nxt == rcs_pkg::S_EXT_HOLD || state_nxt == rcs_pkg::S_COP_PULL;
    assign in_reset = state_r == rcs_pkg::S_OSC_WAIT || state_r == rcs_pkg::S_SETTLE
        || state_r == rcs_pkg::S_EXT_HOLD || state_r == rcs_pkg::S_COP_PULL;
    assign stop_enter = state_r == rcs_pkg::S_RUN && state_nxt == rcs_pkg::S_STOP_OFF;
    assign wait_rise = wait_active && !wait_prev_r;

    // Effects on the rest of the chip
    always_comb begin
        fx_nxt = '0;
        fx_nxt.vector_fetch = state_r == rcs_pkg::S_EXT_HOLD
            && state_nxt == rcs_pkg::S_RUN; // [R01]
        fx_nxt.i_set = rst_lvl_nxt; // [R01]
        fx_nxt.i_clear = stop_enter || (wait_rise && state_r == rcs_pkg::S_RUN); // [R22]
        fx_nxt.timer_init = rst_lvl_nxt; // [R17]
        fx_nxt.ddr_clear = rst_lvl_nxt; // [R17]
        fx_nxt.sp_init = rst_lvl_nxt; // [R17]
        fx_nxt.latch_clear = rst_lvl_nxt; // [R18]
        fx_nxt.sci_init = rst_lvl_nxt; // [R19]
        fx_nxt.clk_clear = state_nxt == rcs_pkg::S_OSC_WAIT || state_nxt == rcs_pkg::S_SETTLE
            || state_nxt == rcs_pkg::S_STOP_OFF
            || state_nxt == rcs_pkg::S_STOP_START; // [R20]
        fx_nxt.adc_off = rst_lvl_nxt || state_nxt == rcs_pkg::S_STOP_OFF
            || state_nxt == rcs_pkg::S_STOP_START; // [R21]
        fx_nxt.nvm_reset = fx_nxt.adc_off; // [R21]
    end

    // Registered outputs towards chip and pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_fx <= '0;
            cpu_reset <= 1'b1;
            osc_enable <= 1'b1;
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= 1'b1;
            wait_prev_r <= 1'b0;
        end else begin
            reset_fx <= fx_nxt;
            cpu_reset <= rst_lvl_nxt;
            osc_enable <= state_nxt != rcs_pkg::S_STOP_OFF; // [R14]
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= !(state_nxt == rcs_pkg::S_OSC_WAIT || state_nxt == rcs_pkg::S_SETTLE
                || state_nxt == rcs_pkg::S_COP_PULL); // [R06] [R03]
            wait_prev_r <= wait_active;
        end
    end

    // ------------------------------------------------------------
    // Watchdog chain
    // ------------------------------------------------------------
    assign wd_clear = supervisor_enable_bit_write_one || state_r != rcs_pkg::S_RUN || wait_rise
        || (wait_active && !opt_wait_supervisor_enable_bit_run); // [R10] [R15] [R22]
    assign wd_tick = misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT] && timer_bit7_carry; // [R08]

    // Divide by 4, by 256, then count to seven
    always_ff @(posedge aclk) begin
        if (!aresetn || wd_clear) begin
            wd_div4_r <= 2'h0;
            wd_div256_r <= 8'h00;
            wd_div8_r <= 3'h0;
        end else if (wd_tick) begin
            wd_div4_r <= 2'(wd_div4_r + 2'h1); // [R07]
            if (wd_div4_r == 2'h3) begin
                wd_div256_r <= 8'(wd_div256_r + 8'h01);
                if (wd_div256_r == 8'hff && wd_div8_r != rcs_pkg::WD_FINAL) begin
                    wd_div8_r <= 3'(wd_div8_r + 3'h1); // [R07] [R11]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_misc = wr_go && aw_addr_r == rcs_pkg::MISC_OFFSET && w_lane_r;
    assign supervisor_enable_bit_write_one = wr_misc && w_data_r[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT];

    // Hardware loads win over software writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            misc_bits <= rcs_pkg::MISC_RESET; // [R04]
        end else if (in_reset) begin
            misc_bits[rcs_pkg::IRQ_RISING_SELECT_BIT] <= 1'b0;
            misc_bits[rcs_pkg::IRQ_FALLING_SELECT_BIT] <= 1'b0;
            misc_bits[rcs_pkg::EXTERNAL_IRQ_ENABLE_BIT] <= 1'b1; // [R18]
            misc_bits[rcs_pkg::SM_BIT] <= 1'b0; // [R21]
            misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT] <= opt_supervisor_enable_bit_at_reset; // [R09] [R16]
        end else if (stop_enter) begin
            misc_bits[rcs_pkg::SM_BIT] <= 1'b0; // [R21]
            misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT] <= 1'b0; // [R21]
        end else if (wr_misc) begin
            if (!w_data_r[rcs_pkg::POR_BIT]) begin
                misc_bits[rcs_pkg::POR_BIT] <= 1'b0; // [R04]
            end
            if (cpu_i_mask) begin
                misc_bits[rcs_pkg::IRQ_RISING_SELECT_BIT] <= w_data_r[rcs_pkg::IRQ_RISING_SELECT_BIT];
                misc_bits[rcs_pkg::IRQ_FALLING_SELECT_BIT] <= w_data_r[rcs_pkg::IRQ_FALLING_SELECT_BIT];
                misc_bits[rcs_pkg::EXTERNAL_IRQ_ENABLE_BIT] <= w_data_r[rcs_pkg::EXTERNAL_IRQ_ENABLE_BIT];
            end
            misc_bits[rcs_pkg::SFA_BIT] <= w_data_r[rcs_pkg::SFA_BIT];
            misc_bits[rcs_pkg::SFB_BIT] <= w_data_r[rcs_pkg::SFB_BIT];
            misc_bits[rcs_pkg::SM_BIT] <= w_data_r[rcs_pkg::SM_BIT];
            if (w_data_r[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT]) begin
                misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT] <= 1'b1; // [R09]
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data taken in either order, answered together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rcs_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_addr_r == rcs_pkg::MISC_OFFSET ? rcs_pkg::RESP_OKAY
                    : rcs_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    // Control register and a read-only status word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rcs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rcs_pkg::RESP_OKAY;
            if (s_axi_araddr == rcs_pkg::MISC_OFFSET) begin
                s_axi_rdata <= {24'h00_0000, misc_bits};
            end else if (s_axi_araddr == rcs_pkg::STATUS_OFFSET) begin
                s_axi_rdata <= {24'h00_0000, cpu_reset, osc_enable, pin_sync_r,
                    2'h0, wd_div8_r};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= rcs_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence pin_low_run_s;
        (state_r == rcs_pkg::S_RUN && !pin_sync_r && !wd_timeout && !stop_req) [*2];
    endsequence
    sequence settle_end_s;
        state_r == rcs_pkg::S_SETTLE ##1 state_r != rcs_pkg::S_SETTLE;
    endsequence

    pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
        (state_r == rcs_pkg::S_SETTLE || state_r == rcs_pkg::S_COP_PULL) |-> !rst_pin_oe_n)
        else $error("reset pin not driven during internal reset");
    settle_len_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
        settle_end_s |-> $past(cnt_r) == settle_last)
        else $error("settle delay has wrong length");
    ext_release_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
        (state_r == rcs_pkg::S_EXT_HOLD && pin_sync_r) |=> state_r == rcs_pkg::S_RUN
        && reset_fx.vector_fetch && !cpu_reset)
        else $error("no resume after pin release");
    ext_detect_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
        pin_low_run_s |=> state_r == rcs_pkg::S_EXT_HOLD && cpu_reset)
        else $error("pin low not taken as reset");
    wd_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        (state_r == rcs_pkg::S_RUN && pin_sync_r && wd_timeout)
        |=> state_r == rcs_pkg::S_COP_PULL ##1 !rst_pin_oe_n)
        else $error("watchdog final state gave no reset");
    wd_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
        (state_r == rcs_pkg::S_RUN && misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT])
        |=> misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT])
        else $error("watchdog disabled while running");
    wd_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        supervisor_enable_bit_write_one |=> wd_div8_r == 3'h0 && wd_div256_r == 8'h00)
        else $error("enable write did not clear watchdog");
    por_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
        !misc_bits[rcs_pkg::POR_BIT] |=> !misc_bits[rcs_pkg::POR_BIT])
        else $error("power-on flag set without power-on");
    cop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        (state_r == rcs_pkg::S_COP_PULL && pin_sync_r) |=> state_r == rcs_pkg::S_COP_PULL)
        else $error("pin released before it was sensed low");
    stop_cop_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
        (state_r == rcs_pkg::S_RUN && pin_sync_r && stop_req && misc_bits[rcs_pkg::SUPERVISOR_ENABLE_BIT_BIT])
        |=> state_r == rcs_pkg::S_COP_PULL && osc_enable)
        else $error("stop not turned into watchdog reset");
endmodule
`default_nettype wire

// >>> testbench/rcs_board.sv
/*
 Board model beside the reset pin: pull-up, open-drain device drive
 and an outside reset source commanded by the bench.
 Assumes the device only ever drives the pin low.
*/
`default_nettype none
module rcs_board (
    input wire logic oe_n,
    input wire logic hold_low,
    output var logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-and of pull-up, device pull-down and outside source
    always_comb begin
        pin = !(!oe_n || hold_low);
    end
endmodule
`default_nettype wire

// >>> testbench/rcs_top_tb.sv
/*
 Self-checking bench of the reset supervisor: register, pin, watchdog
 and stop paths. Assumes the board model and a 100 MHz clock.
*/
`default_nettype none
module rcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic awr, wr_, bv, arr, rv, pin, pout, oe_n, cpu_reset, osc_en, hold = 0;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] misc, v;
    logic osc_ok = 0, carry = 0, stp = 0, wake = 0, imask = 1, wt = 0;
    rcs_pkg::rcs_fx_t fx;
    int fail_count = 0, compares = 0, cyc = 0;
    rcs_top rcs_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .rst_pin_in(pin), .rst_pin_out(pout), .rst_pin_oe_n(oe_n),
        .opt_long_settle(1'b0), .opt_supervisor_enable_bit_at_reset(1'b0), .opt_wait_supervisor_enable_bit_run(1'b0),
        .osc_stable(osc_ok), .timer_bit7_carry(carry), .stop_req(stp), .stop_wake(wake),
        .wait_active(wt), .cpu_i_mask(imask), .cpu_reset(cpu_reset),
        .osc_enable(osc_en), .misc_bits(misc), .reset_fx(fx));
    rcs_board rcs_board_inst (.oe_n(oe_n), .hold_low(hold), .pin(pin));
    // Clock and cycle ceiling
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; br <= 1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wr_) wv <= 0;
        end while (!bv);
        br <= 0; resp = bresp;
    endtask
    task automatic rdb(input logic [11:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1; rr <= 1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 0;
        end while (!rv);
        rr <= 0; v = rd[7:0]; resp = rresp;
    endtask
    task automatic wait_rst(input logic lvl);
        for (int i = 0; i < 200 && cpu_reset !== lvl; i++) @(posedge aclk);
        check("cpu_reset", {7'h0, cpu_reset}, {7'h0, lvl});
    endtask
    task automatic carries(input int n);
        repeat (n) begin
            @(posedge aclk) carry <= 1;
            @(posedge aclk) carry <= 0;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(98));
        repeat (16) @(posedge aclk);
        aresetn <= 1; osc_ok <= 1;
        repeat (4) @(posedge aclk);
        check("pin drive", {7'h0, oe_n}, 8'h00);
        wait_rst(0);
        rdb(12'h00c); check("misc", v, 8'h90);
        wr(12'h00c, 8'h10); rdb(12'h00c); check("misc", v, 8'h10);
        imask <= 0; wr(12'h00c, 8'hff); rdb(12'h00c); check("misc", v, 8'h1f);
        imask <= 1; wr(12'h00c, 8'h10); rdb(12'h00c); check("misc", v, 8'h11);
        wr(12'h020 + 12'(4 * ($urandom % 64)), 8'h5a); check("bresp", resp, 8'h02);
        rdb(12'h100 + 12'(4 * ($urandom % 64))); check("rresp", resp, 8'h02);
        // Watchdog: refresh, then time out exactly
        carries(7000); wr(12'h00c, 8'h11);
        carries(7167); check("cpu_reset", {7'h0, cpu_reset}, 8'h00);
        carries(1); repeat (3) @(posedge aclk);
        check("wd pull", {6'h0, cpu_reset, oe_n}, 8'h02);
        wait_rst(0);
        rdb(12'h00c); check("misc por supervisor_enable_bit", v & 8'h81, 8'h00);
        // Wait entry clears and holds the chain
        wr(12'h00c, 8'h11);
        carries(7000);
        wt <= 1;
        carries(10);
        wt <= 0;
        carries(7167);
        check("wait clear", {7'h0, cpu_reset}, 8'h00);
        // Stop while watchdog runs
        wr(12'h00c, 8'h11);
        @(posedge aclk) stp <= 1;
        @(posedge aclk) stp <= 0;
        repeat (3) @(posedge aclk);
        check("stop wd", {6'h0, cpu_reset, osc_en}, 8'h03);
        wait_rst(0);
        // Stop without watchdog stops the oscillator
        @(posedge aclk) stp <= 1;
        @(posedge aclk) stp <= 0;
        repeat (3) @(posedge aclk);
        check("osc_enable", {7'h0, osc_en}, 8'h00);
        check("stop fx", {5'h0, fx.clk_clear, fx.adc_off, fx.nvm_reset}, 8'h07);
        @(posedge aclk) wake <= 1;
        @(posedge aclk) wake <= 0;
        repeat (4100) @(posedge aclk);
        check("osc_enable", {7'h0, osc_en}, 8'h01);
        // Outside pin: short glitch ignored, longer pulse resets
        @(posedge aclk) hold <= 1;
        @(posedge aclk) hold <= 0;
        repeat (6) @(posedge aclk);
        check("cpu_reset", {7'h0, cpu_reset}, 8'h00);
        @(posedge aclk) hold <= 1;
        repeat (2 + $urandom % 4) @(posedge aclk);
        wait_rst(1);
        check("reset fx", {3'h0, fx.i_set, fx.timer_init, fx.sp_init, fx.latch_clear,
            fx.sci_init}, 8'h1f);
        check("pin out", {7'h0, pout}, 8'h00);
        hold <= 0;
        wait_rst(0);
        check("vector", {7'h0, fx.vector_fetch}, 8'h01);
        rdb(12'h00c); check("misc por", v & 8'h80, 8'h00);
        // Second power-on in mid-run sets the flag again
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        wait_rst(0);
        rdb(12'h00c);
        check("misc reset", v, 8'h90);
        check("misc port", misc, 8'h90);
        report_and_stop();
    end
endmodule
`default_nettype wire
